// ### mpd_top.sv
// Result register of a multiply-accumulate slice with masked pattern detector,
// overflow/underflow pulses and auto-clear, plus its Avalon-MM register port.
// Assumes operands are synchronous to core_clk; fabric handles saturation.
`timescale 1ns/1ps
`default_nettype none
module mpd_top
	import mpd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [DW-1:0] ab_in,
	input wire logic [DW-1:0] c_in,
	input wire logic [DW-1:0] cascade_in,
	input wire logic result_en,
	output logic [DW-1:0] result,
	output logic hit_flag_output,
	output logic inverse_hit_output,
	output logic overflow,
	output logic underflow
);
	logic wait_q;
	logic [31:0] rdata_q;
	logic [47:0] pat_q;
	logic [47:0] mask_q;
	logic [31:0] ctrl_q;
	logic [47:0] result_q;
	logic [47:0] result_d;
	logic hit_q;
	logic inv_q;
	logic hit_past_q;
	logic ovf_q;
	logic unf_q;
	logic bus_go;
	logic wr_go;
	logic [31:0] rd_mux;
	logic pat_dyn;
	logic mask_dyn;
	mpd_rnd_t rnd_mode;
	mpd_op_t op_mode;
	logic simd;
	logic ar_en;
	logic ar_on_leave;
	logic [47:0] eff_pat;
	logic [47:0] sel_mask;
	logic [47:0] eff_mask;
	logic [47:0] add_x;
	logic [47:0] add_y;
	logic add_cin;
	logic [47:0] add_sum;
	logic [LANES-1:0] lane_cout;
	logic hit_d;
	logic inv_d;
	logic auto_clear;
	logic [31:0] pat_hi_m;
	logic [31:0] mask_hi_m;

	// Merge write data into a 32-bit word by byte lanes
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Bus: one wait cycle, completion when waitrequest is low
	assign bus_go = (avs_read | avs_write) & ~wait_q;
	assign wr_go = avs_write & ~wait_q;
	assign pat_hi_m = be_merge({16'h0000, pat_q[47:32]}, avs_writedata, avs_byteenable);
	assign mask_hi_m = be_merge({16'h0000, mask_q[47:32]}, avs_writedata, avs_byteenable);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wait_q <= 1'b1;
		end
		else if (bus_go)
		begin
			wait_q <= 1'b1;
		end
		else if (avs_read | avs_write)
		begin
			wait_q <= 1'b0;
		end
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			ADDR_PAT_LO: rd_mux = pat_q[31:0];
			ADDR_PAT_HI: rd_mux = {16'h0000, pat_q[47:32]};
			ADDR_MASK_LO: rd_mux = mask_q[31:0];
			ADDR_MASK_HI: rd_mux = {16'h0000, mask_q[47:32]};
			ADDR_CTRL: rd_mux = ctrl_q;
			ADDR_RES_LO: rd_mux = result_q[31:0];
			ADDR_RES_HI: rd_mux = {16'h0000, result_q[47:32]};
			ADDR_STAT: rd_mux = {28'h000_0000, unf_q, ovf_q, inv_q, hit_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= 32'h0000_0000;
		end
		else if (avs_read & wait_q)
		begin
			rdata_q <= rd_mux;
		end
	end

	// Stored comparison value and mask
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pat_q <= PAT_RST;
		end
		else if (wr_go && avs_address == ADDR_PAT_LO)
		begin
			pat_q[31:0] <= be_merge(pat_q[31:0], avs_writedata, avs_byteenable);
		end
		else if (wr_go && avs_address == ADDR_PAT_HI)
		begin
			pat_q[47:32] <= pat_hi_m[15:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mask_q <= MASK_RST;
		end
		else if (wr_go && avs_address == ADDR_MASK_LO)
		begin
			mask_q[31:0] <= be_merge(mask_q[31:0], avs_writedata, avs_byteenable);
		end
		else if (wr_go && avs_address == ADDR_MASK_HI)
		begin
			mask_q[47:32] <= mask_hi_m[15:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RST;
		end
		else if (wr_go && avs_address == ADDR_CTRL)
		begin
			ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable) & CTRL_MASKBITS;
		end
	end

	// Detector-used bit is stored and read back only
	assign pat_dyn = ctrl_q[CTRL_PAT_SEL];
	assign mask_dyn = ctrl_q[CTRL_MASK_SEL];
	assign rnd_mode = mpd_rnd_t'(ctrl_q[CTRL_RND_LO +: 2]);
	assign op_mode = mpd_op_t'(ctrl_q[CTRL_OP_LO +: 3]);
	assign simd = ctrl_q[CTRL_SIMD];
	assign ar_en = ctrl_q[CTRL_AR_EN];
	assign ar_on_leave = ctrl_q[CTRL_AR_POL];

	// Pattern and mask sources
	assign eff_pat = pat_dyn ? c_in : pat_q;
	assign sel_mask = mask_dyn ? c_in : mask_q;

	always_comb
	begin
		eff_mask = sel_mask;
		case (rnd_mode)
			MPD_RND_SEL: eff_mask = sel_mask;
			MPD_RND_FRACTION: eff_mask = {~c_in[46:0], 1'b0};
			MPD_RND_ALT: eff_mask = {~c_in[45:0], 2'b00};
			default: eff_mask = sel_mask;
		endcase
	end

	// Adder: accumulate or subtract, lanes split in SIMD mode
	always_comb
	begin
		add_x = result_q;
		add_y = ab_in;
		add_cin = 1'b0;
		if (op_mode == MPD_OP_SUB)
		begin
			add_x = ab_in;
			add_y = ~c_in;
			add_cin = 1'b1;
		end
	end

	for (genvar g = 0; g < LANES; g++)
	begin : g_lane
		logic lane_cin;
		if (g == 0)
		begin : g_first
			assign lane_cin = add_cin;
		end
		else
		begin : g_rest
			assign lane_cin = simd ? add_cin : lane_cout[g-1];
		end
		mpd_lane_add #(.W(LANE_W)) u_add (
			.a(add_x[g*LANE_W +: LANE_W]),
			.b(add_y[g*LANE_W +: LANE_W]),
			.cin(lane_cin),
			.sum(add_sum[g*LANE_W +: LANE_W]),
			.cout(lane_cout[g])
		);
	end

	always_comb
	begin
		result_d = add_sum;
		case (op_mode)
			MPD_OP_ACC: result_d = add_sum;
			MPD_OP_SUB: result_d = add_sum;
			MPD_OP_XNOR: result_d = ab_in ~^ c_in;
			MPD_OP_CASC_XNOR: result_d = cascade_in ~^ ab_in;
			MPD_OP_LOAD: result_d = ab_in;
			default: result_d = add_sum;
		endcase
	end

	// Detect on the next result so flags line up with the register
	mpd_pat_cmp #(.W(DW)) u_cmp (
		.value(result_d),
		.pattern(eff_pat),
		.mask(eff_mask),
		.hit(hit_d),
		.inv_hit(inv_d)
	);

	// Clear on hit, or when a previous hit has gone
	assign auto_clear = ar_en & (ar_on_leave ? (hit_past_q & ~hit_q) : hit_q);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			result_q <= 48'h0000_0000_0000;
		end
		else if (auto_clear)
		begin
			result_q <= 48'h0000_0000_0000;
		end
		else if (result_en)
		begin
			result_q <= result_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			hit_q <= 1'b0;
			inv_q <= 1'b0;
			hit_past_q <= 1'b0;
		end
		else if (auto_clear)
		begin
			hit_q <= 1'b0;
			inv_q <= 1'b0;
			hit_past_q <= 1'b0;
		end
		else if (result_en)
		begin
			hit_q <= hit_d;
			inv_q <= inv_d;
			hit_past_q <= hit_q;
		end
	end

	// Leaving the in-range band from either side, one pulse each
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
		end
		else if (auto_clear || !result_en)
		begin
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
		end
		else
		begin
			ovf_q <= hit_q & ~hit_d & ~inv_d;
			unf_q <= inv_q & ~hit_d & ~inv_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign result = result_q;
	assign hit_flag_output = hit_q;
	assign inverse_hit_output = inv_q;
	assign overflow = ovf_q;
	assign underflow = unf_q;

	ovf_one_cycle_a: assert property (@(posedge core_clk) disable iff (rst) ovf_q |=> !ovf_q)
		else $error("overflow held beyond one cycle");
	unf_one_cycle_a: assert property (@(posedge core_clk) disable iff (rst) unf_q |=> !unf_q)
		else $error("underflow held beyond one cycle");
	ovf_cause_a: assert property (@(posedge core_clk) disable iff (rst) ovf_q |-> $past(hit_q) && !hit_q && !inv_q)
		else $error("overflow without leaving the positive band");
	clear_on_hit_a: assert property (@(posedge core_clk) disable iff (rst)
		ar_en && !ar_on_leave && hit_q && $stable(ctrl_q) |=> result_q == 48'h0000_0000_0000 && !hit_q)
		else $error("auto-clear on hit did not clear");
	clear_on_leave_a: assert property (@(posedge core_clk) disable iff (rst)
		ar_en && ar_on_leave && hit_past_q && !hit_q |=> result_q == 48'h0000_0000_0000)
		else $error("auto-clear on leave did not clear");
	flag_align_a: assert property (@(posedge core_clk) disable iff (rst)
		result_en && !auto_clear |=> hit_q == &((result_q ~^ $past(eff_pat)) | $past(eff_mask)))
		else $error("match flag not aligned with result");
	fraction_mask_a: assert property (@(posedge core_clk) disable iff (rst)
		rnd_mode == MPD_RND_FRACTION |-> eff_mask == {~c_in[46:0], 1'b0})
		else $error("fraction mask wrong");
	mask_source_a: assert property (@(posedge core_clk) disable iff (rst)
		rnd_mode == MPD_RND_SEL |-> eff_mask == (mask_dyn ? c_in : mask_q))
		else $error("mask source wrong");
	pat_source_a: assert property (@(posedge core_clk) disable iff (rst)
		eff_pat == (pat_dyn ? c_in : pat_q))
		else $error("pattern source wrong");
	zero_detect_a: assert property (@(posedge core_clk) disable iff (rst)
		eff_pat == 48'h0000_0000_0000 && eff_mask == 48'h0000_0000_0000 && inv_d |-> &result_d)
		else $error("complement flag without all ones");
	sub_equal_a: assert property (@(posedge core_clk) disable iff (rst)
		op_mode == MPD_OP_SUB && !simd && result_en && !auto_clear |=> result_q == $past(ab_in) - $past(c_in))
		else $error("subtract result wrong");
endmodule
`default_nettype wire

// ### mpd_pkg.sv
// Constants, register map and types of the masked pattern detector slice.
// Assumes a single clock domain and an Avalon-MM register port.
// Operation
// - Detector keeps a 48-bit comparison value and a 48-bit mask.
// - Flag masked equality with the value, and separately with its complement.
// - Mask resets to 48'h3FFFFFFFFFFF and sets the overflow threshold.
// - Comparison value comes from the stored constant or from operand C; stored by default.
// - Mask comes from the stored mask or from operand C; stored by default.
// - Rounding-mask choice: selected mask or two special masks that override selection.
// - First special mask is operand C inverted and shifted left one bit.
// - Flags appear in the same cycle as their result on the registered output.
// - Zero value with default mask flags overflow past bit 46, and underflow likewise.
// - Overflow and underflow flags last exactly one cycle.
// - A mask of N low ones moves overflow point; limits 2^N-1 and -2^N.
// - Value and complement are searched at once; dedicated overflow outputs unused.
// - Zero value and zero mask: match means all zeros, complement means all ones.
// - With XNOR logic, match is a 48-bit equality of C and the concatenated operand.
// - In subtraction, sign gives ordering and match gives equality, same cycle.
// - In four 12-bit lanes, a pattern flags any lane overflow, lane unknown.
// - Auto-clear on hit clears result and match flag one cycle after a match.
// - Auto-clear on leave clears result when a previous match has gone.
// - Auto-clear acts on the whole result register, all lanes together.
// - Detector-used setting has no functional effect.
package mpd_pkg;
	localparam int unsigned DW = 48;
	localparam int unsigned LANE_W = 12;
	localparam int unsigned LANES = 4;
	localparam int unsigned AW = 5;

	localparam logic [4:0] ADDR_PAT_LO = 5'h00;
	localparam logic [4:0] ADDR_PAT_HI = 5'h04;
	localparam logic [4:0] ADDR_MASK_LO = 5'h08;
	localparam logic [4:0] ADDR_MASK_HI = 5'h0C;
	localparam logic [4:0] ADDR_CTRL = 5'h10;
	localparam logic [4:0] ADDR_RES_LO = 5'h14;
	localparam logic [4:0] ADDR_RES_HI = 5'h18;
	localparam logic [4:0] ADDR_STAT = 5'h1C;

	localparam logic [47:0] PAT_RST = 48'h0000_0000_0000;
	localparam logic [47:0] MASK_RST = 48'h3FFF_FFFF_FFFF;

	localparam int unsigned CTRL_PAT_SEL = 0;
	localparam int unsigned CTRL_MASK_SEL = 1;
	localparam int unsigned CTRL_RND_LO = 2;
	localparam int unsigned CTRL_AR_EN = 4;
	localparam int unsigned CTRL_AR_POL = 5;
	localparam int unsigned CTRL_DET_USED = 6;
	localparam int unsigned CTRL_OP_LO = 8;
	localparam int unsigned CTRL_SIMD = 12;
	localparam logic [31:0] CTRL_MASKBITS = 32'h0000_177F;
	localparam logic [31:0] CTRL_RST = 32'h0000_0040;

	localparam int unsigned STAT_HIT = 0;
	localparam int unsigned STAT_INV = 1;
	localparam int unsigned STAT_OVF = 2;
	localparam int unsigned STAT_UNF = 3;

	typedef enum logic [1:0] {
		MPD_RND_SEL = 2'h0,
		MPD_RND_FRACTION = 2'h1,
		MPD_RND_ALT = 2'h2
	} mpd_rnd_t;

	typedef enum logic [2:0] {
		MPD_OP_ACC = 3'h0,
		MPD_OP_SUB = 3'h1,
		MPD_OP_XNOR = 3'h2,
		MPD_OP_CASC_XNOR = 3'h3,
		MPD_OP_LOAD = 3'h4
	} mpd_op_t;
endpackage

// ### mpd_lane_add.sv
// One lane of the result adder, with carry in and carry out.
// Assumes the caller chains or breaks carries between lanes.
`timescale 1ns/1ps
`default_nettype none
module mpd_lane_add #(
	parameter int unsigned W = 12
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic cin,
	output logic [W-1:0] sum,
	output logic cout
);
	logic [W:0] full;

	assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
	assign sum = full[W-1:0];
	assign cout = full[W];
endmodule
`default_nettype wire

// ### mpd_pat_cmp.sv
// Masked comparison of a word against a value and against its complement.
// Assumes mask ones mark bit positions to ignore.
`timescale 1ns/1ps
`default_nettype none
module mpd_pat_cmp #(
	parameter int unsigned W = 48
) (
	input wire logic [W-1:0] value,
	input wire logic [W-1:0] pattern,
	input wire logic [W-1:0] mask,
	output logic hit,
	output logic inv_hit
);
	// Masked bits count as equal in both searches
	assign hit = &((value ~^ pattern) | mask);
	assign inv_hit = &((value ~^ ~pattern) | mask);
endmodule
`default_nettype wire

// ### mpd_fabric_model.sv
// Fabric logic beside the slice: saturation select and top-bit overflow.
// Assumes it watches the slice outputs on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mpd_fabric_model
	import mpd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [DW-1:0] result,
	input wire logic hit_flag_output,
	input wire logic inverse_hit_output,
	input wire logic overflow,
	input wire logic underflow,
	input wire logic [DW-1:0] sat_mask,
	output logic [DW-1:0] sat_value,
	output logic top_ovf,
	output logic top_unf
);
	logic ovf_q;
	logic unf_q;
	logic hit_q;
	logic inv_q;
	logic [DW-1:0] res_q;
	// Pulses last one cycle; register them here with the result, one cycle late
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
			hit_q <= 1'b0;
			inv_q <= 1'b0;
			res_q <= '0;
		end
		else
		begin
			ovf_q <= overflow;
			unf_q <= underflow;
			hit_q <= hit_flag_output;
			inv_q <= inverse_hit_output;
			res_q <= result;
		end
	end
	// Limits follow the loaded mask: N low ones give 2^N-1 and -2^N
	assign sat_value = ovf_q ? sat_mask : (unf_q ? ~sat_mask : res_q);
	// Dedicated pulse pins unused here
	assign top_ovf = hit_q & result[DW-1];
	assign top_unf = inv_q & ~result[DW-1];
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the pattern detector slice.
// Assumes the fabric model sits on the slice outputs.
`timescale 1ns/1ps
`default_nettype none
module tb
	import mpd_pkg::*;
;
	logic core_clk;
	logic rst;
	logic [AW-1:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [DW-1:0] ab_in;
	logic [DW-1:0] c_in;
	logic result_en;
	logic [DW-1:0] result;
	logic hit;
	logic inv;
	logic overflow;
	logic underflow;
	logic [DW-1:0] sat_value;
	logic [DW-1:0] cascade_in;
	logic [DW-1:0] sat_mask;
	logic top_ovf;
	logic top_unf;
	int failures;
	int num_checks;

	mpd_top mpd_top_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ab_in(ab_in), .c_in(c_in),
		.cascade_in(cascade_in), .result_en(result_en), .result(result), .hit_flag_output(hit),
		.inverse_hit_output(inv), .overflow(overflow), .underflow(underflow));
	mpd_fabric_model mpd_fabric_model_i (.core_clk(core_clk), .rst(rst), .result(result),
		.hit_flag_output(hit), .inverse_hit_output(inv), .overflow(overflow), .underflow(underflow),
		.sat_mask(sat_mask), .sat_value(sat_value), .top_ovf(top_ovf), .top_unf(top_unf));

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest);
		avs_write <= 1'b0;
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest);
		d = avs_readdata;
		avs_read <= 1'b0;
		chk({16'h0000, d}, {16'h0000, e});
	endtask

	task automatic pm(input logic [47:0] p, input logic [47:0] m);
		wr(ADDR_PAT_LO, p[31:0]);
		wr(ADDR_PAT_HI, {16'h0000, p[47:32]});
		wr(ADDR_MASK_LO, m[31:0]);
		wr(ADDR_MASK_HI, {16'h0000, m[47:32]});
	endtask

	// One load, flags judged with the result they belong to
	task automatic ldk(input logic [47:0] ab, input logic [47:0] c, input logic eh, input logic ei);
		@(posedge core_clk);
		ab_in <= ab;
		c_in <= c;
		result_en <= 1'b1;
		@(posedge core_clk);
		result_en <= 1'b0;
		#1;
		chk({47'h0, hit}, {47'h0, eh});
		chk({47'h0, inv}, {47'h0, ei});
	endtask

	task automatic t_reset;
		rdc(ADDR_PAT_LO, 32'h0000_0000);
		rdc(ADDR_PAT_HI, 32'h0000_0000);
		rdc(ADDR_MASK_LO, 32'hFFFF_FFFF);
		rdc(ADDR_MASK_HI, 32'h0000_3FFF);
		rdc(ADDR_CTRL, 32'h0000_0040);
		wr(ADDR_RES_LO, 32'hFFFF_FFFF);
		rdc(ADDR_RES_LO, 32'h0000_0000);
	endtask

	task automatic t_static;
		pm(48'h1234_5678_9ABC, 48'h0);
		wr(ADDR_CTRL, 32'h0000_0400);
		ldk(48'h1234_5678_9ABC, 48'h0, 1'b1, 1'b0);
		chk(result, 48'h1234_5678_9ABC);
		rdc(ADDR_STAT, 32'h0000_0001);
		rdc(ADDR_RES_HI, 32'h0000_1234);
		ldk(48'hEDCB_A987_6543, 48'h0, 1'b0, 1'b1);
		ldk(48'h1234_5678_9ABD, 48'h0, 1'b0, 1'b0);
		pm(48'h1234_5678_9ABC, 48'h1);
		ldk(48'h1234_5678_9ABD, 48'h0, 1'b1, 1'b0);
		pm(48'h0, 48'h0);
		ldk(48'h0, 48'h0, 1'b1, 1'b0);
		ldk(48'hFFFF_FFFF_FFFF, 48'h0, 1'b0, 1'b1);
	endtask

	task automatic t_dyn;
		wr(ADDR_CTRL, 32'h0000_0401);
		ldk(48'h0000_ABCD_0001, 48'h0000_ABCD_0001, 1'b1, 1'b0);
		ldk(48'h0000_ABCD_0001, 48'h0000_ABCD_0003, 1'b0, 1'b0);
		wr(ADDR_CTRL, 32'h0000_0402);
		ldk(48'h0000_0000_00F0, 48'h0000_0000_00FF, 1'b1, 1'b0);
		ldk(48'h0000_0000_0100, 48'h0000_0000_00FF, 1'b0, 1'b0);
		wr(ADDR_CTRL, 32'h0000_0406);
		ldk(48'h0000_0000_1230, 48'h0000_0000_0007, 1'b1, 1'b0);
		ldk(48'h0000_0000_1238, 48'h0000_0000_0007, 1'b0, 1'b0);
		wr(ADDR_CTRL, 32'h0000_040A);
		ldk(48'h0000_0000_1210, 48'h0000_0000_0007, 1'b0, 1'b0);
		ldk(48'h0000_0000_1220, 48'h0000_0000_0007, 1'b1, 1'b0);
	endtask

	task automatic t_logic;
		pm(48'hFFFF_FFFF_FFFF, 48'h0);
		wr(ADDR_CTRL, 32'h0000_0200);
		ldk(48'h0123_4567_89AB, 48'h0123_4567_89AB, 1'b1, 1'b0);
		ldk(48'h0123_4567_89AB, 48'h0123_4567_89A3, 1'b0, 1'b0);
		cascade_in <= 48'h0123_4567_89AB;
		wr(ADDR_CTRL, 32'h0000_0300);
		ldk(48'h0123_4567_89AB, 48'h0, 1'b1, 1'b0);
		ldk(48'h0123_4567_89AA, 48'h0, 1'b0, 1'b0);
		pm(48'h0, 48'h0);
		wr(ADDR_CTRL, 32'h0000_0100);
		ldk(48'h5, 48'h5, 1'b1, 1'b0);
		ldk(48'h3, 48'h5, 1'b0, 1'b0);
		chk({47'h0, result[47]}, 48'h1);
	endtask

	task automatic ovk(input logic [47:0] m, input logic [47:0] s, input logic [47:0] a, input logic o,
		input logic [47:0] sv);
		sat_mask <= m;
		pm(48'h0, m);
		wr(ADDR_CTRL, 32'h0000_0400);
		ldk(s, 48'h0, o, ~o);
		wr(ADDR_CTRL, 32'h0000_0000);
		ldk(a, 48'h0, 1'b0, 1'b0);
		chk({46'h0, overflow, underflow}, {46'h0, o, ~o});
		@(posedge core_clk);
		#1;
		chk({46'h0, overflow, underflow}, 48'h0);
		chk(sat_value, sv);
	endtask

	task automatic t_ovf;
		ovk(MASK_RST, 48'h3FFF_FFFF_FFFF, 48'h1, 1'b1, 48'h3FFF_FFFF_FFFF);
		ovk(MASK_RST, 48'hC000_0000_0000, 48'hFFFF_FFFF_FFFF, 1'b0, 48'hC000_0000_0000);
		ovk(48'hFF, 48'hFF, 48'h1, 1'b1, 48'h0000_0000_00FF);
		ovk(48'hFF, 48'hFFFF_FFFF_FF00, 48'hFFFF_FFFF_FFFF, 1'b0, 48'hFFFF_FFFF_FF00);
		pm(48'h7FF0_0000_0000, 48'h000F_FFFF_FFFF);
		wr(ADDR_CTRL, 32'h0000_0400);
		ldk(48'h7FFF_FFFF_FFFF, 48'h0, 1'b1, 1'b0);
		wr(ADDR_CTRL, 32'h0000_0000);
		ldk(48'h0000_0000_0001, 48'h0, 1'b0, 1'b1);
		chk({46'h0, top_ovf, top_unf}, 48'h2);
	endtask

	// Four 12-bit lanes: lane 0 carry dropped, lane 1 overflows
	task automatic t_simd;
		pm(48'h0, 48'h3FF3_FF3F_F3FF);
		wr(ADDR_CTRL, 32'h0000_1400);
		ldk(48'h0000_003F_F3FF, 48'h0, 1'b1, 1'b0);
		wr(ADDR_CTRL, 32'h0000_1000);
		ldk(48'h0000_0000_1C01, 48'h0, 1'b0, 1'b0);
		chk(result, 48'h0000_0040_0000);
		chk({47'h0, overflow}, 48'h1);
	endtask

	// Counter by one from zero; auto-clear per ctl
	task automatic t_clear(input logic [47:0] pat, input logic [31:0] ctl, input logic [47:0] e[5]);
		pm(pat, 48'h0);
		wr(ADDR_CTRL, 32'h0000_0400);
		ldk(48'h0, 48'h0, 1'b0, 1'b0);
		wr(ADDR_CTRL, ctl);
		@(posedge core_clk);
		ab_in <= 48'h1;
		result_en <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			@(posedge core_clk);
			#1;
			chk(result, e[i]);
			chk({47'h0, hit}, {47'h0, e[i] == pat});
		end
		@(posedge core_clk);
		result_en <= 1'b0;
	endtask

	task automatic wrap_up;
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge core_clk);
		failures++;
		wrap_up();
	end

	initial
	begin
		failures = 0;
		num_checks = 0;
		rst = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		ab_in = '0;
		c_in = '0;
		cascade_in = '0;
		sat_mask = MASK_RST;
		result_en = 1'b0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_static();
		t_dyn();
		t_logic();
		t_ovf();
		t_simd();
		t_clear(48'h3, 32'h0000_0010, '{48'h1, 48'h2, 48'h3, 48'h0, 48'h1});
		t_clear(48'h2, 32'h0000_0030, '{48'h1, 48'h2, 48'h3, 48'h0, 48'h1});
		wrap_up();
	end
endmodule
`default_nettype wire
